// ### hdl/ext_bus_consts.vh
// constants for the external bus pin block: register offsets, fields, timing
// assumes byte addressing on an axi4-lite slave with 32-bit data
`ifndef EXT_BUS_CONSTS_VH
`define EXT_BUS_CONSTS_VH

// register byte offsets
`define OFS_BP_CTRL 8'h00
`define OFS_BP_ADDR 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_BUS_STAT 8'h10

// control register fields
`define BIT_BP_EN 0
`define BIT_BP_PULSE 1
`define BIT_BP_HIT 2

// interrupt status fields
`define IRQ_HIT 0
`define IRQ_FIFO 1

// reset value and fetch thresholds
`define ADDR_RST 16'h0000
`define FETCH_LIMIT_INT 16'h1B40
`define FETCH_LIMIT_EXT 16'h0000

// breakpoint pulse timing
`define BP_PULSE_CLKS 8
`define BP_PULSE_REF_MHZ 24
`define SYS_MHZ 25
// eight 24 MHz clocks = 333 ns; at 25 MHz round up to 9 cycles
`define BP_PULSE_CYC ((`BP_PULSE_CLKS * `SYS_MHZ + `BP_PULSE_REF_MHZ - 1) / `BP_PULSE_REF_MHZ)

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### hdl/ext_bus_pins.v
// external memory bus pin driver with breakpoint comparator
// assumes the core presents one access request per cycle on its side ports,
// all inputs except the async reset synchronous to clk_sys, registers reached over axi4-lite
//
// Operation
// [RULE_01] address bus always driven, resets to zero
// [RULE_02] internal ram accesses still show address
// [RULE_03] data bus idle z, read in, write out
// [RULE_04] data bus active only for external accesses
// [RULE_05] suspend drives data bus low
// [RULE_06] fifo strobes move bytes over data bus
// [RULE_07] fetch strobe low only on external fetch
// [RULE_08] fetch threshold 0x1b40 or 0x0000 by select
// [RULE_09] breakpoint out on enabled address match
// [RULE_10] pulse mode gives eight-clock high pulse
// [RULE_11] level mode holds until hit flag cleared
// [RULE_12] 16-bit compare, each match sets hit flag
`timescale 1ns/1ps
`include "ext_bus_consts.vh"

module ext_bus_pins
#(
  parameter PULSE_CYC = `BP_PULSE_CYC
)
(
  input wire clk_sys, // 25 mhz system clock
  input wire reset, // async reset, active high
  // core side
  input wire core_valid, // core access this cycle
  input wire [15:0] core_addr, // core address
  input wire core_write, // 1 write, 0 read
  input wire core_fetch, // access is a code fetch
  input wire core_external, // access targets external memory
  input wire [7:0] core_wdata, // write byte
  output reg [7:0] core_rdata, // byte captured from data bus
  input wire suspend, // device in suspend
  input wire external_code_select, // external code select pin
  // fifo side
  input wire fifo_rd_req, // move byte external fifo -> endpoint
  input wire fifo_wr_req, // move byte endpoint -> external fifo
  input wire [7:0] fifo_wdata, // byte from endpoint fifo
  output reg [7:0] fifo_rdata, // byte to endpoint fifo
  output reg fifo_rdata_valid, // fifo_rdata strobe
  // pins
  output reg [15:0] external_address_bus, // address pins
  input wire [7:0] data_in, // data pin input
  output reg [7:0] data_out, // data pin output
  output reg data_oe, // data pin output enable
  output reg program_fetch_strobe_n, // fetch strobe, active low
  output reg fifo_read_strobe_n, // fifo read strobe, active low
  output reg fifo_write_strobe_n, // fifo write strobe, active low
  output reg breakpoint_out, // breakpoint pin
  output reg irq, // level interrupt
  // axi4-lite
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read valid
  input wire s_axi_rready // read ready
);

  // ************************************************************
  // registers
  // ************************************************************
  reg bp_en_r; // breakpoint enable
  reg bp_pulse_r; // pulse mode
  reg bp_hit_r; // sticky hit flag
  reg [15:0] bp_addr_r; // breakpoint address hi/lo
  reg [1:0] irq_stat_r; // sticky events
  reg [1:0] irq_mask_r; // interrupt mask
  reg [7:0] aw_addr_r; // latched write address
  reg aw_have_r; // write address held
  reg [31:0] w_data_r; // latched write data
  reg [3:0] w_strb_r; // latched strobes
  reg w_have_r; // write data held
  reg [3:0] pulse_cnt_r; // pulse length counter
  reg rd_pend_r; // external read in progress
  reg fifo_rd_pend_r; // fifo read in progress
  reg match_d_r; // match seen last cycle

  wire [15:0] cur_addr; // address on the pins next
  wire ext_read; // external read cycle
  wire ext_write; // external write cycle
  wire ext_fetch; // fetch that goes off chip
  wire match; // comparator output
  wire match_rise; // new match
  wire wr_fire; // register write takes effect
  wire hit_clr; // software clears hit
  wire [1:0] stat_clr; // software clears status
  wire [1:0] events; // event sources

  // ************************************************************
  // decode helpers
  // ************************************************************
  // fetch threshold depends on external code select
  function fetch_goes_out;
    input [15:0] a;
    input sel;
    fetch_goes_out = sel ? (a > `FETCH_LIMIT_EXT) : (a > `FETCH_LIMIT_INT); // RULE_08
  endfunction

  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // keep last address when the core is idle so the bus never floats
  assign cur_addr = core_valid ? core_addr : external_address_bus; // RULE_02
  assign ext_fetch = core_valid & core_fetch & fetch_goes_out(core_addr, external_code_select);
  // internal targets never touch the data bus
  assign ext_read = core_valid & ~core_write & (core_external | ext_fetch); // RULE_04
  assign ext_write = core_valid & core_write & core_external & ~core_fetch; // RULE_04
  assign match = bp_en_r & (cur_addr == bp_addr_r); // RULE_09 RULE_12
  assign match_rise = match & ~match_d_r;
  assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign hit_clr = wr_fire & (aw_addr_r == `OFS_BP_CTRL) & w_strb_r[0] & w_data_r[`BIT_BP_HIT];
  assign stat_clr = (wr_fire & (aw_addr_r == `OFS_IRQ_STAT) & w_strb_r[0])
                    ? w_data_r[1:0] : 2'b00;
  assign events = {fifo_rd_req | fifo_wr_req, match_rise};
  wire [31:0] bp_addr_wr = merge({16'h0000, bp_addr_r}, w_data_r, w_strb_r); // merged, low half kept
  wire [31:0] mask_wr = merge({30'h0, irq_mask_r}, w_data_r, w_strb_r); // merged, low bits kept

  // ************************************************************
  // address bus, fetch strobe and data bus
  // ************************************************************
  // pins are registered; the access is on the pins the cycle after the request
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      external_address_bus <= `ADDR_RST; // RULE_01
      program_fetch_strobe_n <= 1'b1;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      fifo_read_strobe_n <= 1'b1;
      fifo_write_strobe_n <= 1'b1;
      rd_pend_r <= 1'b0;
      fifo_rd_pend_r <= 1'b0;
    end
    else
    begin
      external_address_bus <= cur_addr; // RULE_01 RULE_02
      program_fetch_strobe_n <= ~ext_fetch; // RULE_07
      rd_pend_r <= ext_read & ~suspend;
      fifo_rd_pend_r <= fifo_rd_req & ~suspend & ~core_valid;
      fifo_read_strobe_n <= ~(fifo_rd_req & ~suspend & ~core_valid); // RULE_06
      fifo_write_strobe_n <= ~(fifo_wr_req & ~suspend & ~core_valid & ~fifo_rd_req); // RULE_06
      if (suspend)
      begin
        // driven low rather than left floating
        data_out <= 8'h00; // RULE_05
        data_oe <= 1'b1; // RULE_05
      end
      else if (ext_write)
      begin
        data_out <= core_wdata; // RULE_03
        data_oe <= 1'b1; // RULE_03
      end
      else if (fifo_wr_req & ~core_valid & ~fifo_rd_req)
      begin
        data_out <= fifo_wdata; // RULE_06
        data_oe <= 1'b1;
      end
      else
      begin
        data_out <= 8'h00; // idle, reads and fifo reads release the bus
        data_oe <= 1'b0; // RULE_03 RULE_04
      end
    end
  end

  // capture read data at the end of the read cycle
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      core_rdata <= 8'h00;
      fifo_rdata <= 8'h00;
      fifo_rdata_valid <= 1'b0;
    end
    else
    begin
      if (rd_pend_r)
        core_rdata <= data_in; // RULE_03
      if (fifo_rd_pend_r)
        fifo_rdata <= data_in; // RULE_06
      fifo_rdata_valid <= fifo_rd_pend_r;
    end
  end

  // ************************************************************
  // breakpoint
  // ************************************************************
  // one pulse per new match; a held match does not retrigger
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      match_d_r <= 1'b0;
      pulse_cnt_r <= 4'h0;
      bp_hit_r <= 1'b0;
      breakpoint_out <= 1'b0;
    end
    else
    begin
      match_d_r <= match;
      // set beats a simultaneous clear
      if (match_rise)
        bp_hit_r <= 1'b1; // RULE_12
      else if (hit_clr)
        bp_hit_r <= 1'b0; // RULE_11
      if (match_rise & bp_pulse_r)
        pulse_cnt_r <= PULSE_CYC[3:0]; // RULE_10
      else if (pulse_cnt_r != 4'h0)
        pulse_cnt_r <= pulse_cnt_r - 4'h1;
      if (bp_pulse_r)
        breakpoint_out <= (match_rise | (pulse_cnt_r > 4'h1)); // RULE_10
      else
        breakpoint_out <= match_rise | (bp_hit_r & ~hit_clr); // RULE_11
    end
  end

  // ************************************************************
  // axi4-lite slave and interrupt
  // ************************************************************
  // write address and data accepted in either order, then one response
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
      bp_en_r <= 1'b0;
      bp_pulse_r <= 1'b0;
      bp_addr_r <= 16'h0000;
      irq_mask_r <= 2'b00;
      irq_stat_r <= 2'b00;
      irq <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        case (aw_addr_r)
          `OFS_BP_CTRL:
            if (w_strb_r[0])
            begin
              bp_en_r <= w_data_r[`BIT_BP_EN];
              bp_pulse_r <= w_data_r[`BIT_BP_PULSE];
            end
          `OFS_BP_ADDR:
            bp_addr_r <= bp_addr_wr[15:0];
          `OFS_IRQ_MASK:
            irq_mask_r <= mask_wr[1:0];
          `OFS_IRQ_STAT: ;
          default:
            s_axi_bresp <= `RESP_SLVERR; // unmapped
        endcase
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // reads
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFS_BP_CTRL: s_axi_rdata <= {29'h0, bp_hit_r, bp_pulse_r, bp_en_r};
          `OFS_BP_ADDR: s_axi_rdata <= {16'h0000, bp_addr_r};
          `OFS_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_r};
          `OFS_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_r};
          `OFS_BUS_STAT: s_axi_rdata <= {13'h0, breakpoint_out, data_oe,
                                         program_fetch_strobe_n, external_address_bus};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      // sticky events, set wins over write-one clear
      irq_stat_r <= events | (irq_stat_r & ~stat_clr);
      irq <= |((events | (irq_stat_r & ~stat_clr)) & irq_mask_r);
    end
  end

endmodule

// ### verif/ext_bus_pins_assertions.sv
// port-level checker for the external bus pin block
// assumes binding into ext_bus_pins, single clock domain
`timescale 1ns/1ps
module ext_bus_pins_checker
(
  input logic clk_sys, // clock
  input logic reset, // reset
  input logic core_valid, // access
  input logic [15:0] core_addr, // address
  input logic core_write, // write
  input logic core_fetch, // fetch
  input logic core_external, // external
  input logic [7:0] core_wdata, // byte
  input logic suspend, // suspend
  input logic external_code_select, // select
  input logic fifo_rd_req, // fifo read
  input logic [15:0] external_address_bus, // pins
  input logic [7:0] data_out, // drive
  input logic data_oe, // enable
  input logic program_fetch_strobe_n, // strobe
  input logic fifo_read_strobe_n // strobe
);
  // ****
  // pin relations, one cycle after the access edge except the same-cycle reset check
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_rst; $fell(reset) |-> external_address_bus == 16'h0000 && !data_oe; endproperty
  a_rst: assert property (p_rst) else $error("pins not at reset level");
  property p_addr; core_valid |=> external_address_bus == $past(core_addr); endproperty
  a_addr: assert property (p_addr) else $error("address pins miss access");
  property p_wr; core_valid && core_write && core_external && !suspend
    |=> data_oe && data_out == $past(core_wdata); endproperty
  a_wr: assert property (p_wr) else $error("write byte not driven");
  property p_int; core_valid && !core_external && !core_fetch && !suspend |=> !data_oe; endproperty
  a_int: assert property (p_int) else $error("data bus driven internally");
  property p_susp; suspend |=> data_oe && data_out == 8'h00; endproperty
  a_susp: assert property (p_susp) else $error("suspend not low");
  property p_fifo; fifo_rd_req && !core_valid && !suspend |=> !fifo_read_strobe_n; endproperty
  a_fifo: assert property (p_fifo) else $error("fifo strobe missing");
  property p_fno; core_valid && core_fetch && !external_code_select && core_addr <= 16'h1B40
    |=> program_fetch_strobe_n; endproperty
  a_fno: assert property (p_fno) else $error("fetch strobe below limit");
  property p_fgo; core_valid && core_fetch && (external_code_select ? core_addr != 16'h0000
    : core_addr > 16'h1B40) |=> !program_fetch_strobe_n; endproperty
  a_fgo: assert property (p_fgo) else $error("fetch strobe missing");
endmodule
bind ext_bus_pins ext_bus_pins_checker u_ext_bus_pins_checker (.*);

// ### verif/ext_mem_model.sv
// far-side memory and fifo on the data pins
// assumes data_oe high means the block drives the pins
`timescale 1ns/1ps
module ext_mem_model
(
  input wire clk_sys, // clock
  input wire [15:0] external_address_bus, // address
  input wire [7:0] data_out, // block drive
  input wire data_oe, // block enable
  input wire fifo_read_strobe_n, // fifo read
  input wire fifo_write_strobe_n, // fifo write
  output logic [7:0] data_in // wire level
);
  // ****
  // memory keyed on the low address byte only, to stay small
  // ****
  logic [7:0] mem [0:255]; // storage
  logic [7:0] fifo_byte_r = 8'h3C; // next fifo byte
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ 8'hA5;
  end
  // wire level: block drive wins over far side
  always @*
  begin
    if (data_oe)
      data_in = data_out;
    else if (!fifo_read_strobe_n)
      data_in = fifo_byte_r;
    else
      data_in = mem[external_address_bus[7:0]];
  end
  // fifo returns the inverse of its last write, so data is proven
  always @(posedge clk_sys)
  begin
    if (data_oe && !fifo_write_strobe_n)
      fifo_byte_r <= ~data_out;
    else if (data_oe)
      mem[external_address_bus[7:0]] <= data_out;
  end
endmodule

// ### verif/external_bus_pins_breakpoint_bench.sv
// self-checking bench for the external bus pin block
// assumes ext_bus_pins, ext_mem_model and the bound checker
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module external_bus_pins_breakpoint_bench;
  logic clk_sys = 1'b0, reset = 1'b1, core_valid = 0, core_write = 0, core_fetch = 0;
  logic core_external = 0, suspend = 0, external_code_select = 0, fifo_rd_req = 0;
  logic fifo_wr_req = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, fifo_rdata_valid, data_oe, irq;
  logic program_fetch_strobe_n, fifo_read_strobe_n, fifo_write_strobe_n, breakpoint_out;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] core_addr = 0, external_address_bus, a;
  logic [7:0] core_wdata = 0, fifo_wdata = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [7:0] data_in, core_rdata, fifo_rdata, data_out, exp_f;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, r, seed = 32'h0000_0005;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] rq[$], exp_r;
  logic [7:0] fq[$];
  logic [15:0] fa [4] = '{16'h1B40, 16'h1B41, 16'h0000, 16'h0001}; // fetch table
  int n_errors = 0, num_checks = 0, n;
  ext_bus_pins u_ext_bus_pins (.*);
  ext_mem_model u_ext_mem_model (.*);
  always #20 clk_sys = ~clk_sys;
  // ****
  // bus tasks and result watcher
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic acc(input logic w, f, x, input logic [15:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    {core_valid, core_write, core_fetch, core_external} <= {1'b1, w, f, x};
    core_addr <= ad;
    core_wdata <= d;
    @(posedge clk_sys);
    core_valid <= 1'b0;
    #1;
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    `CHK("bresp", 2'b00, s_axi_bresp)
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic axr(input logic [7:0] ad, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk_sys);
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    s_axi_araddr <= ad;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // oldest note is compared whenever a result shows
  always @(posedge clk_sys)
  begin
    if (s_axi_rvalid && s_axi_rready)
    begin
      exp_r = rq.pop_front();
      `CHK("axi read", exp_r, {s_axi_rresp, s_axi_rdata})
    end
    if (fifo_rdata_valid)
    begin
      exp_f = fq.pop_front();
      `CHK("fifo byte", exp_f, fifo_rdata)
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_errors++;
    report_and_stop();
  end
  // ****
  // scenarios
  // ****
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    `CHK("addr reset", 16'h0000, external_address_bus)
    axr(8'h10, 34'h0_0001_0000);
    axr(8'h00, 34'h0_0000_0000);
    axr(8'h40, 34'h2_0000_0000);
    r = xs();
    a = {8'h40, r[15:8]};
    acc(1, 0, 1, a, r[7:0]);
    `CHK("write oe", 1'b1, data_oe)
    `CHK("write byte", r[7:0], data_out)
    acc(0, 0, 1, a, 8'h00);
    `CHK("read oe", 1'b0, data_oe)
    @(posedge clk_sys);
    #1;
    `CHK("read byte", r[7:0], core_rdata)
    acc(1, 0, 0, 16'h0123, r[23:16]);
    `CHK("int addr", 16'h0123, external_address_bus)
    `CHK("int oe", 1'b0, data_oe)
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      external_code_select <= i[1];
      acc(0, 1, 0, fa[i], 8'h00);
      `CHK("fetch", ~i[0], program_fetch_strobe_n)
    end
    @(posedge clk_sys);
    #1;
    `CHK("fetch idle", 1'b1, program_fetch_strobe_n)
    @(posedge clk_sys);
    fifo_wr_req <= 1'b1;
    fifo_wdata <= r[31:24];
    @(posedge clk_sys);
    fifo_wr_req <= 1'b0;
    #1;
    `CHK("fifo wr strobe", 1'b0, fifo_write_strobe_n)
    `CHK("fifo wr byte", r[31:24], data_out)
    fq.push_back(~r[31:24]);
    @(posedge clk_sys);
    fifo_rd_req <= 1'b1;
    @(posedge clk_sys);
    fifo_rd_req <= 1'b0;
    #1;
    `CHK("fifo rd strobe", 1'b0, fifo_read_strobe_n)
    axw(8'h04, 32'h0000_1234);
    axw(8'h00, 32'h0000_0003);
    axw(8'h08, 32'h0000_0003);
    acc(0, 0, 0, 16'h1234, 8'h00);
    n = 0;
    while (breakpoint_out && n < 40)
    begin
      n++;
      @(posedge clk_sys);
      #1;
    end
    `CHK("pulse len", 9, n)
    axr(8'h00, 34'h0_0000_0007);
    `CHK("irq masked", 1'b0, irq)
    axr(8'h08, 34'h0_0000_0001);
    axw(8'h0C, 32'h0000_0001);
    `CHK("irq on", 1'b1, irq)
    axw(8'h08, 32'h0000_0001);
    `CHK("irq clear", 1'b0, irq)
    acc(0, 0, 0, 16'h0000, 8'h00);
    axw(8'h00, 32'h0000_0005);
    `CHK("level idle", 1'b0, breakpoint_out)
    acc(0, 0, 0, 16'h1234, 8'h00);
    repeat (20) @(posedge clk_sys);
    #1;
    `CHK("level hold", 1'b1, breakpoint_out)
    acc(0, 0, 0, 16'h0000, 8'h00);
    axw(8'h00, 32'h0000_0005);
    `CHK("level clear", 1'b0, breakpoint_out)
    @(posedge clk_sys);
    suspend <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK("suspend oe", 1'b1, data_oe)
    `CHK("suspend byte", 8'h00, data_out)
    report_and_stop();
  end
endmodule
